// *** sec_set_pkg.sv ***
package sec_set_pkg;
  // frame delimiters
  localparam logic [7:0] COMMAND_FRAME_START = 8'h01;
  localparam logic [7:0] DATA_FRAME_START = 8'h02;
  localparam logic [7:0] FINAL_FRAME_END = 8'h03;
  localparam logic [7:0] CONTINUED_FRAME_END = 8'h17;
  // status codes
  localparam logic [7:0] ST_ACK = 8'h06;
  localparam logic [7:0] ST_PARAM = 8'h05;
  localparam logic [7:0] ST_SUM = 8'h07;
  localparam logic [7:0] ST_NACK = 8'h15;
  localparam logic [7:0] ST_PROTECT = 8'h10;
  localparam logic [7:0] ST_WRITE = 8'h1a;
  localparam logic [7:0] ST_VERIFY = 8'h1b;
  // command code value is arbitrary
  localparam logic [7:0] CMD_SECURITY_SET = 8'ha0;
  localparam logic [7:0] CMD_LEN = 8'h03;
  localparam logic [7:0] DATA_LEN = 8'h02;
  localparam logic [7:0] STATUS_LEN = 8'h01;
  localparam logic [2:0] CMD_LAST = 3'h6;
  localparam logic [2:0] DATA_LAST = 3'h5;
  localparam logic [2:0] STATUS_LAST = 3'h4;
  localparam logic [7:0] FLAG_FORCED = 8'hf0;
  localparam int BOOT_GUARD_BIT = 3;
  localparam logic [7:0] FLAGS_RESET = 8'hff;
  localparam logic [7:0] BOOT_RESET = 8'h00;
  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_WRTIME = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_WFAIL = 1;
  localparam int CTRL_VFAIL = 2;
  localparam int CTRL_RELEASE = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_CMD_PROC = 4'h1, S_ST1 = 4'h2, S_DAT_RX = 4'h3,
    S_WR_PROC = 4'h4, S_ST2 = 4'h5, S_VFY_PROC = 4'h6, S_ST3 = 4'h7,
    S_STALL = 4'h8
  } state_t;
  typedef struct packed {
    logic overrun;
    logic fail;
    logic done;
  } evt_t;
endpackage

// *** security_set_responder.sv ***
`timescale 1ns/1ns
// Behaviour
// - busy held past the limit makes programmer time out, no status.
// - enabling an already prohibited flag answers protect error 10H.
// - changing boot end while boot rewrite prohibited answers 10H.
// - a failed security write reports 1AH in the write status.
// - a failed internal verify reports 1BH in the final status.
module security_set_responder
  import sec_set_pkg::*;
#(
  parameter int CMD_CYCLES = 8,
  parameter int VERIFY_CYCLES = 16,
  parameter logic [15:0] WRITE_CYCLES = 16'h0020,
  parameter int BUSY_LIMIT = 1000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic link_sck,
  input wire logic link_si,
  output logic link_so,
  output logic handshake_busy_pin,
  output logic irq
);
  import sec_set_pkg::*;

  if (CMD_CYCLES < 1 || VERIFY_CYCLES < 1 || BUSY_LIMIT < 2 ||
      BUSY_LIMIT > 65535 || CMD_CYCLES >= BUSY_LIMIT ||
      VERIFY_CYCLES >= BUSY_LIMIT)
    $error("security_set_responder: bad cycle parameters");

  localparam logic [15:0] CMD_END = 16'(CMD_CYCLES - 1);
  localparam logic [15:0] VFY_END = 16'(VERIFY_CYCLES - 1);
  localparam logic [15:0] LIMIT_END = 16'(BUSY_LIMIT - 1);

  state_t state;
  evt_t ev;
  logic [2:0] idx, bit_cnt;
  logic [15:0] cnt, wr_time;
  logic [7:0] code, tx_byte, rx_byte, rx_shift, tx_shift;
  logic [7:0] sec_flags, boot_end;
  logic [7:0] frame [0:6];
  logic [3:0] ctrl;
  logic [2:0] irq_status, irq_en;
  logic tx_load, commit, rx_done, release_stall;
  logic sck_s1, sck_s2, sck_s3, si_s1, si_s2;
  logic [7:0] aw_addr, cmd_sum, dat_sum, cmd_status, dat_status;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held, w_held, do_write;

  // byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == ADDR_CTRL || a == ADDR_STATUS || a == ADDR_FLAGS ||
           a == ADDR_WRTIME || a == ADDR_IRQ_STATUS ||
           a == ADDR_IRQ_CLEAR || a == ADDR_IRQ_ENABLE;
  endfunction

  // status frame: start, length, code, checksum, end
  function automatic logic [7:0] stat_byte(input logic [2:0] i,
                                           input logic [7:0] c);
    case (i)
      3'h0: stat_byte = DATA_FRAME_START;
      3'h1: stat_byte = STATUS_LEN;
      3'h2: stat_byte = c;
      3'h3: stat_byte = 8'(8'h00 - STATUS_LEN - c);
      default: stat_byte = FINAL_FRAME_END;
    endcase
  endfunction

  // link pins cross into aclk through two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {sck_s1, sck_s2, sck_s3, si_s1, si_s2} <= 5'h00;
    end else begin
      sck_s1 <= link_sck;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      si_s1 <= link_si;
      si_s2 <= si_s1;
    end
  end

  // receive: sample on rising sck, msb first
  always_ff @(posedge aclk) begin
    rx_done <= 1'b0;
    if (!aresetn || !ctrl[CTRL_ENABLE]) begin
      bit_cnt <= 3'h0;
      rx_shift <= 8'h00;
      rx_byte <= 8'h00;
    end else if (sck_s2 && !sck_s3) begin
      rx_shift <= {rx_shift[6:0], si_s2};
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        rx_done <= 1'b1;
        rx_byte <= {rx_shift[6:0], si_s2};
      end
    end
  end

  // transmit: first bit shown at load, the rest on falling sck
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_so <= 1'b0;
      tx_shift <= 8'h00;
    end else if (tx_load) begin
      link_so <= tx_byte[7];
      tx_shift <= {tx_byte[6:0], 1'b0};
    end else if (!sck_s2 && sck_s3 && bit_cnt != 3'h0) begin
      link_so <= tx_shift[7];
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

  // frame capture buffer
  always_ff @(posedge aclk) begin
    if (rx_done && (state == S_IDLE || state == S_DAT_RX)) begin
      frame[idx] <= rx_byte;
    end
  end

  // checks run on the buffered frame while busy is shown
  assign cmd_sum = frame[1] + frame[2] + frame[3] + frame[4] + frame[5];
  assign dat_sum = frame[1] + frame[2] + frame[3] + frame[4];
  always_comb begin
    if (frame[1] != CMD_LEN || frame[6] != FINAL_FRAME_END) begin
      cmd_status = ST_NACK;
    end else if (cmd_sum != 8'h00) begin
      cmd_status = ST_SUM;
    end else if (frame[2] != CMD_SECURITY_SET) begin
      cmd_status = ST_NACK;
    end else if ((frame[3] | frame[4]) != 8'h00) begin
      cmd_status = ST_PARAM;
    end else begin
      cmd_status = ST_ACK;
    end
  end
  always_comb begin
    if (frame[1] != DATA_LEN || (frame[5] != FINAL_FRAME_END &&
        frame[5] != CONTINUED_FRAME_END)) begin
      dat_status = ST_PARAM;
    end else if (dat_sum != 8'h00) begin
      dat_status = ST_SUM;
    end else if ((frame[2] & FLAG_FORCED) != FLAG_FORCED) begin
      dat_status = ST_PARAM;
    end else if ((frame[2][3:0] & ~sec_flags[3:0]) != 4'h0) begin
      dat_status = ST_PROTECT;
    end else if (!sec_flags[BOOT_GUARD_BIT] && frame[3] != boot_end) begin
      dat_status = ST_PROTECT;
    end else if (ctrl[CTRL_WFAIL]) begin
      dat_status = ST_WRITE;
    end else begin
      dat_status = ST_ACK;
    end
  end

  // sequence engine
  always_ff @(posedge aclk) begin
    tx_load <= 1'b0;
    commit <= 1'b0;
    ev <= '0;
    if (!aresetn) begin
      state <= S_IDLE;
      idx <= 3'h0;
      cnt <= 16'h0000;
      code <= ST_ACK;
      tx_byte <= 8'h00;
    end else if (!ctrl[CTRL_ENABLE]) begin
      state <= S_IDLE;
      idx <= 3'h0;
    end else begin
      case (state)
        S_IDLE, S_DAT_RX: begin
          if (rx_done) begin
            // a stray byte before the start byte is dropped
            if (idx == 3'h0 && rx_byte != (state == S_IDLE ?
                COMMAND_FRAME_START : DATA_FRAME_START)) begin
              idx <= 3'h0;
            end else if (idx == (state == S_IDLE ? CMD_LAST : DATA_LAST))
                begin
              idx <= 3'h0;
              cnt <= 16'h0000;
              state <= (state == S_IDLE) ? S_CMD_PROC : S_WR_PROC;
            end else begin
              idx <= idx + 3'h1;
            end
          end
        end
        S_CMD_PROC, S_WR_PROC, S_VFY_PROC: begin
          cnt <= cnt + 16'h0001;
          if (cnt == LIMIT_END) begin
            // overrun: busy stays up so the programmer times out
            state <= S_STALL;
            ev.overrun <= 1'b1;
          end else if (state == S_CMD_PROC && cnt == CMD_END) begin
            code <= cmd_status;
            state <= S_ST1;
          end else if (state == S_WR_PROC && cnt >= wr_time) begin
            code <= dat_status;
            commit <= (dat_status == ST_ACK);
            state <= S_ST2;
          end else if (state == S_VFY_PROC && cnt == VFY_END) begin
            code <= ctrl[CTRL_VFAIL] ? ST_VERIFY : ST_ACK;
            state <= S_ST3;
          end
          idx <= 3'h0;
          tx_load <= 1'b1;
          tx_byte <= stat_byte(3'h0, code);
        end
        S_ST1, S_ST2, S_ST3: begin
          if (rx_done && idx == STATUS_LAST) begin
            idx <= 3'h0;
            cnt <= 16'h0000;
            if (code != ST_ACK) begin
              state <= S_IDLE;
              ev.fail <= 1'b1;
            end else if (state == S_ST1) begin
              state <= S_DAT_RX;
            end else if (state == S_ST2) begin
              state <= S_VFY_PROC;
            end else begin
              state <= S_IDLE;
              ev.done <= 1'b1;
            end
          end else if (rx_done) begin
            idx <= idx + 3'h1;
            tx_load <= 1'b1;
            tx_byte <= stat_byte(idx + 3'h1, code);
          end
        end
        S_STALL: begin
          if (release_stall) begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // busy while processing, stalled or disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      handshake_busy_pin <= 1'b1;
    end else begin
      handshake_busy_pin <= !ctrl[CTRL_ENABLE] || state == S_CMD_PROC ||
        state == S_WR_PROC || state == S_VFY_PROC || state == S_STALL;
    end
  end

  // axi write channels: address and data taken in either order
  assign do_write = aw_held && w_held && !bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {awready, wready, aw_held, w_held, bvalid} <= 5'b11000;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        aw_held <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
        w_held <= 1'b1;
        wready <= 1'b0;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        {bvalid, aw_held, w_held, awready, wready} <= 5'b00011;
      end
    end
  end

  // software registers; a write to release is a one-cycle pulse
  always_ff @(posedge aclk) begin
    release_stall <= 1'b0;
    if (!aresetn) begin
      ctrl <= 4'h0;
      wr_time <= WRITE_CYCLES;
      irq_en <= 3'h0;
    end else if (do_write) begin
      if (aw_addr == ADDR_CTRL) begin
        // release is a pulse, so bit 3 is never stored
        ctrl <= 4'(merge({28'h0, ctrl}, w_data, w_strb) & 32'h0000_0007);
        release_stall <= w_strb[0] && w_data[CTRL_RELEASE];
      end
      if (aw_addr == ADDR_WRTIME) begin
        wr_time <= 16'(merge({16'h0, wr_time}, w_data, w_strb));
      end
      if (aw_addr == ADDR_IRQ_ENABLE) begin
        irq_en <= 3'(merge({29'h0, irq_en}, w_data, w_strb));
      end
    end
  end

  // stored security setting; a successful write wins over software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_flags <= FLAGS_RESET;
      boot_end <= BOOT_RESET;
    end else if (commit) begin
      sec_flags <= frame[2];
      boot_end <= frame[3];
    end else if (do_write && aw_addr == ADDR_FLAGS) begin
      {boot_end, sec_flags} <=
        16'(merge({16'h0, boot_end, sec_flags}, w_data, w_strb));
    end
  end

  // sticky events: a new event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~((do_write && w_strb[0] &&
        aw_addr == ADDR_IRQ_CLEAR) ? w_data[2:0] : 3'h0)) | ev;
      irq <= |(irq_status & irq_en);
    end
  end

  // axi read channel, one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        ADDR_CTRL: rdata <= {28'h0, ctrl};
        ADDR_STATUS: rdata <= {16'h0, code, 3'h0, handshake_busy_pin,
                               4'(state)};
        ADDR_FLAGS: rdata <= {16'h0, boot_end, sec_flags};
        ADDR_WRTIME: rdata <= {16'h0, wr_time};
        ADDR_IRQ_STATUS: rdata <= {29'h0, irq_status};
        ADDR_IRQ_ENABLE: rdata <= {29'h0, irq_en};
        default: rdata <= 32'h0000_0000;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule

// *** security_set_properties.sv ***
`timescale 1ns/1ns
module security_set_checker #(
  parameter int BUSY_LIMIT = 1000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic handshake_busy_pin
);
  int busy_run;
  int quiet;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // busy run length, and cycles since software last wrote anything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_run <= 0;
      quiet <= 0;
    end else begin
      busy_run <= handshake_busy_pin ? busy_run + 1 : 0;
      quiet <= (awvalid && awready) ? 0 : quiet + 1;
    end
  end
  // both halves of a write taken at one edge
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  // the answer comes on the second edge, never the first
  sequence s_wr_answer;
    !bvalid ##1 bvalid;
  endsequence
  a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
    else $error("write response late or early");
  a_aw_backoff: assert property (awvalid && awready |=> !awready)
    else $error("write address still ready after take");
  a_ready_held: assert property ($rose(bvalid) |-> !awready && !wready)
    else $error("write channels open while response pending");
  a_b_done: assert property (bvalid && bready |=> !bvalid)
    else $error("write response outlived its handshake");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data not one cycle after address");
  a_read_done: assert property (rvalid && rready |=> !rvalid)
    else $error("read data outlived its handshake");
  // a stall may only be left by a software write
  a_stall_holds: assert property (
    busy_run >= BUSY_LIMIT && quiet >= 8 |=> handshake_busy_pin)
    else $error("busy dropped after the processing limit");
endmodule
bind security_set_responder security_set_checker #(
  .BUSY_LIMIT(BUSY_LIMIT)
) u_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .rready(rready), .handshake_busy_pin(handshake_busy_pin));

// *** sec_programmer.sv ***
`timescale 1ns/1ns
module sec_programmer #(
  parameter int WAIT_LIMIT = 150
) (
  input wire logic aclk,
  input wire logic handshake_busy_pin,
  input wire logic link_so,
  output logic link_sck,
  output logic link_si
);
  import sec_set_pkg::*;
  // sck idles low; data line is flipped after a byte so no stale level
  initial begin
    link_sck = 1'b0;
    link_si = 1'b0;
  end
  // one byte msb first, gap between bytes
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      link_si = tx[i];
      #80;
      rx[i] = link_so;
      link_sck = 1'b1;
      #80;
      link_sck = 1'b0;
    end
    link_si = ~tx[0];
    #203;
  endtask
  task automatic send(input logic [7:0] q[$]);
    logic [7:0] d;
    foreach (q[i]) xbyte(q[i], d);
  endtask
  // fresh counter per wait; 3 ns offset keeps sck off the aclk edges
  task automatic wait_ready(output bit to);
    int n;
    n = 0;
    @(posedge aclk);
    while (handshake_busy_pin !== 1'b0 && n < WAIT_LIMIT) begin
      @(posedge aclk);
      n++;
    end
    to = (handshake_busy_pin !== 1'b0);
    #3;
  endtask
  // whole exchange; returns the last status code and its frame
  task automatic run(input logic [7:0] block_param_byte, security_flag_byte, bot,
    output logic [7:0] code, output bit to, output logic [39:0] last);
    logic [7:0] q[$];
    logic [7:0] nf;
    nf = security_flag_byte | 8'hf0;
    code = 8'h00;
    last = '0;
    wait_ready(to);
    if (to) return;
    q = {COMMAND_FRAME_START, CMD_LEN, CMD_SECURITY_SET, block_param_byte, 8'h00};
    q.push_back(8'h00 - CMD_LEN - CMD_SECURITY_SET - block_param_byte);
    q.push_back(FINAL_FRAME_END);
    send(q);
    for (int s = 0; s < 3; s++) begin
      wait_ready(to);
      if (to) return;
      for (int i = 4; i >= 0; i--) xbyte(8'h00, last[i*8 +: 8]);
      code = last[23:16];
      if (code !== ST_ACK || s == 2) return;
      if (s == 0) begin
        wait_ready(to);
        if (to) return;
        q = {DATA_FRAME_START, DATA_LEN, nf, bot};
        q.push_back(8'h00 - DATA_LEN - nf - bot);
        q.push_back(FINAL_FRAME_END);
        send(q);
      end
    end
  endtask
endmodule

// *** tb_security_set_responder.sv ***
`timescale 1ns/1ns
module tb_security_set_responder;
  import sec_set_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, to;
  logic [7:0] awaddr, araddr, m_flags, m_boot, code, r;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic link_sck, link_si, link_so, handshake_busy_pin;
  logic [39:0] last;
  int fail_count, checked, cyc;
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  security_set_responder #(.BUSY_LIMIT(100)) u_security_set_responder (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .link_sck(link_sck),
    .link_si(link_si), .link_so(link_so), .irq(irq),
    .handshake_busy_pin(handshake_busy_pin));
  sec_programmer u_sec_programmer (.aclk(aclk), .link_so(link_so),
    .handshake_busy_pin(handshake_busy_pin), .link_sck(link_sck),
    .link_si(link_si));
  task automatic check(input string what, input logic [39:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // master holds each channel until taken, bready until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) done = 1;
    end
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    bit done;
    done = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) done = 1;
    end
    rd_v = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  // reference model of the stored setting, then one full exchange
  task automatic seq(input logic [7:0] block_param_byte, security_flag_byte, bot, input bit wf, vf);
    logic [7:0] nf, e;
    nf = security_flag_byte | 8'hf0;
    if (block_param_byte !== 8'h00) e = ST_PARAM;
    else if ((nf[3:0] & ~m_flags[3:0]) != 0) e = ST_PROTECT;
    else if (!m_flags[3] && bot != m_boot) e = ST_PROTECT;
    else if (wf) e = ST_WRITE;
    else begin
      m_flags = nf;
      m_boot = bot;
      e = vf ? ST_VERIFY : ST_ACK;
    end
    wr(ADDR_CTRL, {29'h0, vf, wf, 1'b1});
    u_sec_programmer.run(block_param_byte, security_flag_byte, bot, code, to, last);
    check("timed out", to, 1'b0);
    check("status", code, e);
    check("frame", last, {8'h02, 8'h01, e, 8'h00 - 8'h01 - e, 8'h03});
    rd(ADDR_FLAGS);
    check("flags", rd_v, {16'h0, m_boot, m_flags});
    $display("test done: status %h", e);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      end_of_test();
    end
  end
  // each exchange ends before the next begins
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0_0000_0000_000f;
    m_flags = FLAGS_RESET;
    m_boot = BOOT_RESET;
    void'($urandom(76));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    check("busy", handshake_busy_pin, 1'b1);
    rd(ADDR_WRTIME);
    check("wrtime", rd_v, 32'h20);
    rd(8'h40);
    check("unmapped rd", {rsp, rd_v}, {RESP_SLVERR, 32'h0});
    wr(8'h40, 32'h1);
    check("unmapped wr", rsp, RESP_SLVERR);
    $display("test done: registers");
    seq(8'h00, 8'hff, 8'($urandom), 1'b0, 1'b0);
    rd(ADDR_IRQ_STATUS);
    check("irq status", rd_v, 32'h1);
    check("irq masked", irq, 1'b0);
    wr(ADDR_IRQ_ENABLE, 32'h7);
    repeat (3) @(posedge aclk);
    check("irq on", irq, 1'b1);
    wr(ADDR_IRQ_CLEAR, 32'h7);
    repeat (3) @(posedge aclk);
    check("irq off", irq, 1'b0);
    $display("test done: interrupts");
    seq(8'h00, 8'hff, m_boot, 1'b1, 1'b0);
    seq(8'h00, 8'hff, m_boot, 1'b0, 1'b1);
    seq(8'h01, 8'hff, m_boot, 1'b0, 1'b0);
    seq(8'h00, 8'hf7, m_boot, 1'b0, 1'b0);
    seq(8'h00, 8'hf7, m_boot + 8'h01, 1'b0, 1'b0);
    seq(8'h00, 8'hff, m_boot, 1'b0, 1'b0);
    repeat (3) begin
      r = 8'($urandom);
      seq(8'h00, r, 8'($urandom), 1'b0, 1'b0);
    end
    wr(ADDR_WRTIME, 32'hc8);
    wr(ADDR_CTRL, 32'h1);
    u_sec_programmer.run(8'h00, m_flags, m_boot, code, to, last);
    check("stall", to, 1'b1);
    rd(ADDR_IRQ_STATUS);
    check("overrun", rd_v[2], 1'b1);
    wr(ADDR_CTRL, 32'h9);
    repeat (3) @(posedge aclk);
    check("released", handshake_busy_pin, 1'b0);
    $display("test done: overrun");
    end_of_test();
  end
endmodule
